// ===== rtl/spg_select.sv
`timescale 1ns/1ps
module spg_select #(
    parameter int NUM_GROUPS  = 4,
    parameter int NUM_MASTERS = 2,
    parameter int GIW         = (NUM_GROUPS > 1) ? $clog2(NUM_GROUPS) : 1,
    parameter int MIW         = (NUM_MASTERS > 1) ? $clog2(NUM_MASTERS) : 1
) (
    input  wire logic            clk,
    input  wire logic            reset,
    input  wire logic [4:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output logic [31:0]          avs_readdata,
    output logic                 avs_waitrequest,
    input  wire logic            sp_write,
    input  wire logic [MIW-1:0]  sp_master,
    input  wire logic [GIW-1:0]  sp_group,
    input  wire logic [4:0]      sp_bit,
    output logic                 sp_accept,
    output logic                 sp_trigger
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0]                 en_mask_reg;
    logic [31:0]                 tr_mask_reg;
    spg_pkg::spg_psel_t          pctl_reg;
    logic [11:0]                 gsel_reg;
    logic                        mctl_reg;
    logic [16:0]                 msel_reg;
    logic [15:0]                 trig_count_reg;
    logic                        wait_reg;
    logic [31:0]                 rdata_reg;
    logic                        accept_reg;
    logic                        trigger_reg;
    logic [31:0]                 wdata_next;
    logic [31:0]                 rdata_next;
    logic                        req;
    logic                        done;
    logic                        group_hit;
    logic                        master_hit;
    logic                        enabled;
    logic                        trigger;
    logic                        en_bit;
    logic                        tr_bit;

    localparam logic MULTI_MASTER = (NUM_MASTERS > 1);

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Avalon handshake
    // ------------------------------------------------------------
    // Every access waits one cycle; the fixed latency keeps read data and write
    // effects aligned to one edge without a separate response path.
    assign req  = avs_read || avs_write;
    assign done = req && !wait_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            wait_reg <= 1'b1;
        end else if (req && wait_reg) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    always_comb begin
        unique case (avs_address)
            spg_pkg::OFF_ENABLE_MASK:  rdata_next = en_mask_reg;
            spg_pkg::OFF_TRIGGER_MASK: rdata_next = tr_mask_reg;
            spg_pkg::OFF_GROUP_CFG:    rdata_next = {gsel_reg, 18'h0_0000, pctl_reg};
            spg_pkg::OFF_MASTER_CFG:   rdata_next = MULTI_MASTER ?
                                           {msel_reg, 14'h0000, mctl_reg} : spg_pkg::READ_ZERO;
            spg_pkg::OFF_STATUS:       rdata_next = {trig_count_reg, 14'h0000,
                                                     trigger_reg, accept_reg};
            default:                   rdata_next = spg_pkg::READ_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg <= spg_pkg::READ_ZERO;
        end else if (avs_read && wait_reg) begin
            rdata_reg <= rdata_next;
        end
    end

    assign wdata_next = avs_writedata;

    // ------------------------------------------------------------
    // Mask and selection registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            en_mask_reg <= spg_pkg::MASK_RST;
            tr_mask_reg <= spg_pkg::MASK_RST;
        end else if (done && avs_write) begin
            if (avs_address == spg_pkg::OFF_ENABLE_MASK) begin
                en_mask_reg <= merge(en_mask_reg, wdata_next, avs_byteenable);
            end
            if (avs_address == spg_pkg::OFF_TRIGGER_MASK) begin
                tr_mask_reg <= merge(tr_mask_reg, wdata_next, avs_byteenable);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pctl_reg <= spg_pkg::PSEL_UNUSED;
            gsel_reg <= spg_pkg::GSEL_RST;
        end else if (done && avs_write && avs_address == spg_pkg::OFF_GROUP_CFG) begin
            if (avs_byteenable[0]) begin
                pctl_reg <= spg_pkg::spg_psel_t'(
                    wdata_next[spg_pkg::PCTL_LSB +: spg_pkg::PCTL_W]);
            end
            if (avs_byteenable[3]) begin
                gsel_reg[11:4] <= wdata_next[31:24];
            end
            if (avs_byteenable[2]) begin
                gsel_reg[3:0] <= wdata_next[23:20];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mctl_reg <= spg_pkg::MCTL_RST;
            msel_reg <= spg_pkg::MSEL_RST;
        end else if (MULTI_MASTER && done && avs_write &&
                     avs_address == spg_pkg::OFF_MASTER_CFG) begin
            if (avs_byteenable[0]) begin
                mctl_reg <= wdata_next[spg_pkg::MCTL_BIT];
            end
            if (avs_byteenable[3]) begin
                msel_reg[16:9] <= wdata_next[31:24];
            end
            if (avs_byteenable[2]) begin
                msel_reg[8:1] <= wdata_next[23:16];
            end
            if (avs_byteenable[1]) begin
                msel_reg[0] <= wdata_next[15];
            end
        end
    end

    // ------------------------------------------------------------
    // Selection decode
    // ------------------------------------------------------------
    spg_sel_match #(.W(spg_pkg::GSEL_W)) group_match (
        .field (gsel_reg),
        .index (11'(sp_group)),
        .hit   (group_hit)
    );

    spg_sel_match #(.W(spg_pkg::MSEL_W)) master_match (
        .field (msel_reg),
        .index (16'(sp_master)),
        .hit   (master_hit)
    );

    spg_port_gate port_gate (
        .en_mask    (en_mask_reg),
        .tr_mask    (tr_mask_reg),
        .bit_sel    (sp_bit),
        .pctl       (pctl_reg),
        .group_hit  (group_hit),
        .mctl       (mctl_reg),
        .master_hit (master_hit),
        .enabled    (enabled),
        .trigger    (trigger)
    );

    assign en_bit = en_mask_reg[sp_bit];
    assign tr_bit = tr_mask_reg[sp_bit];

    // ------------------------------------------------------------
    // Per-write results
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            accept_reg  <= 1'b0;
            trigger_reg <= 1'b0;
        end else begin
            accept_reg  <= sp_write && enabled;
            trigger_reg <= sp_write && trigger;
        end
    end

    // The counter wraps silently; software reads differences, not totals.
    always_ff @(posedge clk) begin
        if (reset) begin
            trig_count_reg <= 16'h0000;
        end else if (sp_write && trigger) begin
            trig_count_reg <= trig_count_reg + 16'h0001;
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign sp_accept       = accept_reg;
    assign sp_trigger      = trigger_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    trig_needs_en_a: assert property (@(posedge clk) disable iff (reset)
        sp_trigger |-> sp_accept)
        else $error("trigger without enabled port");

    unused_mode_a: assert property (@(posedge clk) disable iff (reset)
        sp_write && pctl_reg == spg_pkg::PSEL_UNUSED && !mctl_reg
        |=> sp_accept == $past(en_bit))
        else $error("unused mode must follow enable mask bit");

    full_mode_a: assert property (@(posedge clk) disable iff (reset)
        sp_write && pctl_reg == spg_pkg::PSEL_BOTH && !group_hit
        |=> !sp_accept && !sp_trigger)
        else $error("unselected group enabled in full mode");

    trig_only_a: assert property (@(posedge clk) disable iff (reset)
        sp_write && pctl_reg == spg_pkg::PSEL_TRIG && !group_hit && !mctl_reg
        |=> !sp_trigger && sp_accept == $past(en_bit))
        else $error("trigger-only mode mishandled");

    single_group_a: assert property (@(posedge clk) disable iff (reset)
        gsel_reg[0] |-> group_hit == (gsel_reg[11:1] == 11'(sp_group)))
        else $error("single group select mismatch");

    all_groups_a: assert property (@(posedge clk) disable iff (reset)
        gsel_reg == 12'h800 |-> group_hit)
        else $error("top bit alone must select all groups");

    master_off_a: assert property (@(posedge clk) disable iff (reset)
        sp_write && mctl_reg && !master_hit |=> !sp_accept && !sp_trigger)
        else $error("unselected master enabled");

    all_masters_a: assert property (@(posedge clk) disable iff (reset)
        msel_reg == 17'h1_0000 |-> master_hit)
        else $error("top bit alone must select all masters");

    reset_ctl_a: assert property (@(posedge clk)
        $past(reset) && !reset |-> pctl_reg == spg_pkg::PSEL_UNUSED && !mctl_reg)
        else $error("control fields not cleared by reset");

    single_master_a: assert property (@(posedge clk) disable iff (reset)
        !MULTI_MASTER |-> !mctl_reg && (avs_readdata != 32'hffff_ffff) &&
            (!(avs_read && !avs_waitrequest && avs_address == spg_pkg::OFF_MASTER_CFG) ||
             avs_readdata == spg_pkg::READ_ZERO))
        else $error("master register active with one master");

    bus_answer_a: assert property (@(posedge clk) disable iff (reset)
        req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");

    unused_trig_a: assert property (@(posedge clk) disable iff (reset)
        sp_write && pctl_reg == spg_pkg::PSEL_UNUSED && !mctl_reg
        |=> sp_trigger == ($past(en_bit) && $past(tr_bit)))
        else $error("unused mode must follow trigger mask bit");

    master_free_a: assert property (@(posedge clk) disable iff (reset)
        sp_write && !mctl_reg && pctl_reg == spg_pkg::PSEL_BOTH && group_hit
        |=> sp_accept == $past(en_bit))
        else $error("master field must be ignored when master control is off");

    count_step_a: assert property (@(posedge clk) disable iff (reset)
        trig_count_reg == 16'($past(trig_count_reg) + {15'h0000, sp_trigger}))
        else $error("trigger counter out of step with trigger pulses");
endmodule

// ===== rtl/spg_pkg.sv
package spg_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFF_ENABLE_MASK  = 5'h00;
    localparam logic [4:0] OFF_TRIGGER_MASK = 5'h04;
    localparam logic [4:0] OFF_GROUP_CFG    = 5'h08;
    localparam logic [4:0] OFF_MASTER_CFG   = 5'h0c;
    localparam logic [4:0] OFF_STATUS       = 5'h10;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    localparam int GSEL_LSB  = 20;
    localparam int GSEL_W    = 12;
    localparam int PCTL_LSB  = 0;
    localparam int PCTL_W    = 2;
    localparam int MSEL_LSB  = 15;
    localparam int MSEL_W    = 17;
    localparam int MCTL_BIT  = 0;
    localparam int GROUP_W   = 32;
    localparam int BIT_IDX_W = 5;
    localparam int COUNT_W   = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0]     MASK_RST = 32'h0000_0000;
    localparam logic [11:0]     GSEL_RST = 12'h000;
    localparam logic [16:0]     MSEL_RST = 17'h0_0000;
    localparam logic            MCTL_RST = 1'b0;
    localparam logic [31:0]     READ_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // Port selection modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PSEL_UNUSED = 2'b00,
        PSEL_TRIG   = 2'b01,
        PSEL_RSVD   = 2'b10,
        PSEL_BOTH   = 2'b11
    } spg_psel_t;

endpackage

// ===== rtl/spg_sel_match.sv
`timescale 1ns/1ps
module spg_sel_match #(
    parameter int W = 12
) (
    input  wire logic [W-1:0] field,
    input  wire logic [W-2:0] index,
    output logic              hit
);
    // Ones in every position below the lowest set bit of the field.
    logic [W-1:0] below;

    assign below = ~field & (field - {{(W-1){1'b0}}, 1'b1});

    // An all-zero field matches nothing, a safe answer for an undefined setting.
    assign hit = (field != '0) && (((field[W-1:1] ^ index) & ~below[W-2:0]) == '0);
endmodule

// ===== rtl/spg_port_gate.sv
`timescale 1ns/1ps
module spg_port_gate (
    input  wire logic [31:0]             en_mask,
    input  wire logic [31:0]             tr_mask,
    input  wire logic [4:0]              bit_sel,
    input  wire spg_pkg::spg_psel_t      pctl,
    input  wire logic                    group_hit,
    input  wire logic                    mctl,
    input  wire logic                    master_hit,
    output logic                         enabled,
    output logic                         trigger
);
    logic master_ok;
    logic en_scope;
    logic tr_scope;

    always_comb begin
        master_ok = !mctl || master_hit;
        unique case (pctl)
            spg_pkg::PSEL_TRIG: begin
                en_scope = 1'b1;
                tr_scope = group_hit;
            end
            spg_pkg::PSEL_BOTH: begin
                en_scope = group_hit;
                tr_scope = group_hit;
            end
            // The reserved code behaves as unused so a stray write cannot block every port.
            default: begin
                en_scope = 1'b1;
                tr_scope = 1'b1;
            end
        endcase
        enabled = master_ok && en_scope && en_mask[bit_sel];
        trigger = enabled && tr_scope && tr_mask[bit_sel];
    end
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // Signals and rows
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  pctl;
        logic [11:0] gsel;
        logic        mctl;
        logic [16:0] msel;
        logic [4:0]  en_bit;
        logic [4:0]  tr_bit;
        logic        m;
        logic [1:0]  g;
        logic [4:0]  b;
        logic [1:0]  want;
    } spg_row_t;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic [31:0] single_readdata;
    logic        avs_waitrequest;
    logic        sp_write = 1'b0;
    logic        sp_master = 1'b0;
    logic [1:0]  sp_group = 2'h0;
    logic [4:0]  sp_bit = 5'h00;
    logic        sp_accept;
    logic        sp_trigger;
    logic [31:0] rd;
    logic [31:0] rd_single;
    int          bad_count = 0;
    int          checked = 0;
    // Columns: pctl gsel mctl msel en tr master group bit {accept,trigger}.
    spg_row_t    rows [20] = '{
        '{2'h0, 12'h003, 1'h0, 17'h0_0000, 5'h00, 5'h00, 1'h1, 2'h2, 5'h00, 2'h3},
        '{2'h0, 12'h003, 1'h0, 17'h0_0000, 5'h00, 5'h00, 1'h0, 2'h3, 5'h01, 2'h0},
        '{2'h1, 12'h003, 1'h0, 17'h0_0000, 5'h00, 5'h00, 1'h0, 2'h0, 5'h00, 2'h2},
        '{2'h1, 12'h003, 1'h0, 17'h0_0000, 5'h00, 5'h00, 1'h0, 2'h1, 5'h00, 2'h3},
        '{2'h3, 12'h003, 1'h0, 17'h0_0000, 5'h00, 5'h00, 1'h0, 2'h0, 5'h00, 2'h0},
        '{2'h3, 12'h003, 1'h0, 17'h0_0000, 5'h00, 5'h00, 1'h0, 2'h1, 5'h00, 2'h3},
        '{2'h3, 12'h800, 1'h0, 17'h0_0000, 5'h00, 5'h00, 1'h0, 2'h3, 5'h00, 2'h3},
        '{2'h3, 12'h006, 1'h0, 17'h0_0000, 5'h00, 5'h00, 1'h0, 2'h2, 5'h00, 2'h3},
        '{2'h3, 12'h006, 1'h0, 17'h0_0000, 5'h00, 5'h00, 1'h0, 2'h1, 5'h00, 2'h0},
        '{2'h2, 12'h003, 1'h0, 17'h0_0000, 5'h00, 5'h00, 1'h0, 2'h3, 5'h00, 2'h3},
        '{2'h0, 12'h003, 1'h0, 17'h0_0000, 5'h05, 5'h05, 1'h0, 2'h0, 5'h06, 2'h0},
        '{2'h3, 12'h003, 1'h0, 17'h0_0000, 5'h05, 5'h05, 1'h0, 2'h0, 5'h05, 2'h0},
        '{2'h0, 12'h003, 1'h0, 17'h0_0000, 5'h1f, 5'h1f, 1'h0, 2'h1, 5'h1f, 2'h3},
        '{2'h0, 12'h003, 1'h0, 17'h0_0003, 5'h00, 5'h00, 1'h0, 2'h0, 5'h00, 2'h3},
        '{2'h0, 12'h003, 1'h1, 17'h0_0003, 5'h00, 5'h00, 1'h0, 2'h0, 5'h00, 2'h0},
        '{2'h0, 12'h003, 1'h1, 17'h0_0003, 5'h00, 5'h00, 1'h1, 2'h0, 5'h00, 2'h3},
        '{2'h0, 12'h003, 1'h1, 17'h1_0000, 5'h00, 5'h00, 1'h0, 2'h0, 5'h00, 2'h3},
        '{2'h3, 12'h003, 1'h1, 17'h0_0003, 5'h00, 5'h00, 1'h1, 2'h1, 5'h00, 2'h3},
        '{2'h3, 12'h003, 1'h1, 17'h0_0003, 5'h00, 5'h00, 1'h1, 2'h0, 5'h00, 2'h0},
        '{2'h0, 12'h003, 1'h1, 17'h0_0002, 5'h00, 5'h00, 1'h0, 2'h0, 5'h00, 2'h3}
    };

    always #5 clk = ~clk;

    spg_select #(.NUM_GROUPS(4), .NUM_MASTERS(2)) i_spg_select (
        .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sp_write(sp_write), .sp_master(sp_master),
        .sp_group(sp_group), .sp_bit(sp_bit), .sp_accept(sp_accept), .sp_trigger(sp_trigger));

    // A single-master copy shares the bus, so its master register can be seen to vanish.
    spg_select #(.NUM_GROUPS(4), .NUM_MASTERS(1)) i_spg_select_single (
        .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(single_readdata),
        .avs_waitrequest(), .sp_write(sp_write), .sp_master(sp_master),
        .sp_group(sp_group), .sp_bit(sp_bit), .sp_accept(), .sp_trigger());

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk_word(input string name, input logic [31:0] want, input logic [31:0] got);
        checked++;
        if (got !== want) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, want, got);
        end
    endtask

    task automatic chk_bits(input string name, input logic [1:0] want, input logic [1:0] got);
        checked++;
        if (got !== want) begin
            bad_count++;
            $display("BAD %s expected %b seen %b", name, want, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        // Only the watchdog ends a wait that never sees waitrequest low.
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rd_single = single_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic setup(input spg_row_t r);
        bus(1'b1, spg_pkg::OFF_ENABLE_MASK, 32'h0000_0001 << r.en_bit, 4'hf);
        bus(1'b1, spg_pkg::OFF_TRIGGER_MASK, 32'h0000_0001 << r.tr_bit, 4'hf);
        bus(1'b1, spg_pkg::OFF_GROUP_CFG, {r.gsel, 18'h0_0000, r.pctl}, 4'hf);
        bus(1'b1, spg_pkg::OFF_MASTER_CFG, {r.msel, 14'h0000, r.mctl}, 4'hf);
    endtask

    // The result pulse is read at the edge after it was launched, while still standing.
    task automatic pulse(input logic m, input logic [1:0] g, input logic [4:0] b);
        @(posedge clk);
        sp_write <= 1'b1;
        sp_master <= m;
        sp_group <= g;
        sp_bit <= b;
        @(posedge clk);
        sp_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [1:0] burst [4];
        burst = '{2'h3, 2'h0, 2'h3, 2'h0};
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            setup(rows[i]);
            pulse(rows[i].m, rows[i].g, rows[i].b);
            chk_bits("accept trigger", rows[i].want, {sp_accept, sp_trigger});
            $display("test row %0d done", i);
        end
        @(posedge clk);
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        chk_bits("idle after reset", 2'b10, {avs_waitrequest, sp_accept || sp_trigger});
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0000_0000, 4'hf);
            chk_word("reset value", 32'h0000_0000, rd);
        end
        $display("test reset done");
        bus(1'b1, spg_pkg::OFF_MASTER_CFG, 32'hffff_ffff, 4'hf);
        bus(1'b0, spg_pkg::OFF_MASTER_CFG, 32'h0000_0000, 4'hf);
        chk_word("master config", 32'hffff_8001, rd);
        chk_word("single master config", 32'h0000_0000, rd_single);
        bus(1'b1, spg_pkg::OFF_GROUP_CFG, 32'hffff_ffff, 4'hf);
        bus(1'b0, spg_pkg::OFF_GROUP_CFG, 32'h0000_0000, 4'hf);
        chk_word("group config", 32'hfff0_0003, rd);
        bus(1'b1, spg_pkg::OFF_ENABLE_MASK, 32'hffff_ffff, 4'h2);
        bus(1'b0, spg_pkg::OFF_ENABLE_MASK, 32'h0000_0000, 4'hf);
        chk_word("enable lanes", 32'h0000_ff00, rd);
        bus(1'b1, 5'h14, 32'hffff_ffff, 4'hf);
        bus(1'b0, 5'h14, 32'h0000_0000, 4'hf);
        chk_word("unmapped", 32'h0000_0000, rd);
        bus(1'b1, spg_pkg::OFF_STATUS, 32'hffff_ffff, 4'hf);
        bus(1'b0, spg_pkg::OFF_STATUS, 32'h0000_0000, 4'hf);
        chk_word("status read only", 32'h0000_0000, rd);
        $display("test registers done");
        setup(rows[0]);
        for (int i = 0; i < 5; i++) begin
            sp_write <= (i < 4);
            sp_bit <= (i == 1 || i == 3) ? 5'h01 : 5'h00;
            @(posedge clk);
            if (i > 0) chk_bits("burst", burst[i - 1], {sp_accept, sp_trigger});
        end
        sp_write <= 1'b0;
        bus(1'b0, spg_pkg::OFF_STATUS, 32'h0000_0000, 4'hf);
        chk_word("trigger count", 32'h0002_0000, rd);
        $display("test burst done");
        report_and_stop();
    end
endmodule
